// file: rtl/btcalu_core.sv
/*
  Bit test, leading bit count, accumulator clear and signed, magnitude and
  unsigned compare, with the condition flag register and a mode register.
  Assumes operands arrive with op_valid from the decoder and register file,
  and that memory data answers in the same cycle as mem_rd.
*/
// Our own choices: strobed register access and the address map.
`timescale 1ns/1ps
`include "btcalu_map.svh"

module btcalu_core (
  // clock and reset
  input logic ref_clk,
  input logic reset_n,
  // register port
  input logic [3:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic reg_wr,
  input logic reg_rd,
  output logic [7:0] reg_rdata,
  // operation request
  input logic op_valid,
  output logic op_ready,
  input btcalu_pkg::btcalu_op_e op_code,
  input btcalu_pkg::btcalu_btsrc_e bt_src,
  input logic [4:0] bit_num,
  input logic [5:0] addr_field,
  input logic [23:0] ea_addr,
  input logic mem_space_sel,
  input logic [23:0] reg_operand,
  input btcalu_pkg::btcalu_s1_e s1_kind,
  input logic [55:0] s1_acc,
  input logic [23:0] s1_word,
  input logic [23:0] imm_long,
  input logic [55:0] s2_acc,
  input logic dest_sel,
  // memory operand
  output logic mem_rd,
  output logic mem_space,
  output logic [23:0] mem_addr,
  input logic [23:0] mem_rdata,
  // results
  output logic op_done,
  output logic acc_wr_en,
  output logic acc_wr_sel,
  output logic [55:0] acc_wr_data,
  output logic sp_dec,
  output logic [7:0] condition_flags
);

  btcalu_pkg::btcalu_state_s st;
  btcalu_pkg::btcalu_state_s next_st;

  function automatic logic pick_bit(input logic [23:0] w, input logic [4:0] n);
    pick_bit = (n <= `BTCALU_BIT_MAX) ? w[n] : 1'b0;
  endfunction

  function automatic logic [23:0] lead_count(input logic [55:0] v, input logic m16);
    logic [55:0] s;
    logic [6:0] w;
    logic [6:0] n;
    logic run;
    s = m16 ? {v[55:32], v[23:8], 16'h0000} : v;
    w = m16 ? `BTCALU_LEAD_W_SIXTEEN : `BTCALU_LEAD_W_NORMAL;
    n = 7'h00;
    run = 1'b1;
    for (int i = 55; i >= 0; i--) begin
      if (run && (7'(55 - i) < w) && (s[i] == s[55])) begin
        n = n + 7'h01;
      end else begin
        run = 1'b0;
      end
    end
    if (s == 56'h0) begin
      lead_count = 24'h000000;
    end else begin
      lead_count = `BTCALU_LEAD_BIAS - {17'h00000, n};
    end
  endfunction

  function automatic logic [55:0] abs56(input logic [55:0] v);
    abs56 = v[55] ? (56'h0 - v) : v;
  endfunction

  logic [55:0] s1_full;
  logic [55:0] cmp_a;
  logic [55:0] cmp_b;
  logic [56:0] diff;
  logic [55:0] r;
  logic ovf;
  logic ext_use;
  logic [47:0] u_s1;
  logic [48:0] udiff;
  logic [23:0] lead_res;
  logic [23:0] s1_w24;
  logic [23:0] bt_word;

  always_comb begin
    // first operand as a 24-bit word
    unique case (s1_kind)
      btcalu_pkg::S1_IMM_SHORT: s1_w24 = {18'h00000, s1_word[5:0]};
      btcalu_pkg::S1_IMM_LONG: s1_w24 = imm_long;
      default: s1_w24 = s1_word;
    endcase
    s1_full = (s1_kind == btcalu_pkg::S1_ACC) ? s1_acc : {{8{s1_w24[23]}}, s1_w24, 24'h000000};
    cmp_a = (op_code == btcalu_pkg::OP_MAGN_CMP) ? abs56(s2_acc) : s2_acc;
    cmp_b = (op_code == btcalu_pkg::OP_MAGN_CMP) ? abs56(s1_full) : s1_full;
    diff = {1'b0, cmp_a} - {1'b0, cmp_b};
    r = diff[55:0];
    ovf = (cmp_a[55] ^ cmp_b[55]) & (r[55] ^ cmp_a[55]);
    ext_use = ~((&r[55:47]) | ~(|r[55:47]));
    u_s1 = (s1_kind == btcalu_pkg::S1_ACC) ? s1_acc[47:0] : {s1_w24, 24'h000000};
    udiff = {1'b0, s2_acc[47:0]} - {1'b0, u_s1};
    lead_res = lead_count(s1_acc, st.mode16);
    bt_word = reg_operand;
  end

  always_comb begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.acc_wr_en = 1'b0;
    next_st.mem_rd = 1'b0;
    next_st.sp_dec = 1'b0;
    next_st.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `BTCALU_OFS_FLAGS: next_st.rdata = st.flags;
        `BTCALU_OFS_MODE: next_st.rdata = {7'h00, st.mode16};
        default: next_st.rdata = 8'h00;
      endcase
    end
    if (reg_wr) begin
      if (reg_addr == `BTCALU_OFS_FLAGS) begin
        next_st.flags = reg_wdata;
      end
      if (reg_addr == `BTCALU_OFS_MODE) begin
        next_st.mode16 = reg_wdata[`BTCALU_MODE_SIXTEEN];
      end
    end
    // operation updates below override a same-cycle software write
    unique case (st.state)
      btcalu_pkg::ST_IDLE: begin
        if (op_valid) begin
          next_st.done = 1'b1;
          unique case (op_code)
            btcalu_pkg::OP_BIT_TEST: begin
              next_st.bit_q = bit_num;
              next_st.mem_space = mem_space_sel;
              unique case (bt_src)
                btcalu_pkg::BT_REG, btcalu_pkg::BT_STACK: begin
                  next_st.flags[`BTCALU_F_C] = pick_bit(bt_word, bit_num);
                  next_st.sp_dec = (bt_src == btcalu_pkg::BT_STACK);
                end
                default: begin
                  next_st.done = 1'b0;
                  next_st.mem_rd = 1'b1;
                  next_st.state = btcalu_pkg::ST_FETCH;
                  unique case (bt_src)
                    btcalu_pkg::BT_MEM_ABS: next_st.mem_addr = {18'h00000, addr_field};
                    btcalu_pkg::BT_MEM_PP: next_st.mem_addr = {`BTCALU_PP_BASE, addr_field};
                    btcalu_pkg::BT_MEM_QQ: next_st.mem_addr = {`BTCALU_QQ_BASE, addr_field};
                    default: next_st.mem_addr = ea_addr;
                  endcase
                end
              endcase
            end
            btcalu_pkg::OP_LEAD_COUNT: begin
              next_st.acc_wr_en = 1'b1;
              next_st.acc_wr_sel = dest_sel;
              next_st.acc_wr_data = {{8{lead_res[23]}}, lead_res, 24'h000000};
              next_st.flags[`BTCALU_F_N] = lead_res[23];
              next_st.flags[`BTCALU_F_Z] = (lead_res == 24'h000000);
              next_st.flags[`BTCALU_F_V] = 1'b0;
            end
            btcalu_pkg::OP_ACC_CLEAR: begin
              next_st.acc_wr_en = 1'b1;
              next_st.acc_wr_sel = dest_sel;
              next_st.acc_wr_data = 56'h0;
              next_st.flags[`BTCALU_F_E] = 1'b0;
              next_st.flags[`BTCALU_F_U] = 1'b1;
              next_st.flags[`BTCALU_F_N] = 1'b0;
              next_st.flags[`BTCALU_F_Z] = 1'b1;
              next_st.flags[`BTCALU_F_V] = 1'b0;
            end
            btcalu_pkg::OP_SIGNED_CMP, btcalu_pkg::OP_MAGN_CMP: begin
              next_st.flags[`BTCALU_F_C] = diff[56];
              next_st.flags[`BTCALU_F_V] = ovf;
              next_st.flags[`BTCALU_F_Z] = (r == 56'h0);
              next_st.flags[`BTCALU_F_N] = r[55];
              next_st.flags[`BTCALU_F_E] = ext_use;
              next_st.flags[`BTCALU_F_U] = ~(r[47] ^ r[46]) & ~ext_use;
              next_st.flags[`BTCALU_F_L] = st.flags[`BTCALU_F_L] | ovf;
            end
            btcalu_pkg::OP_UNSIGNED_CMP: begin
              next_st.flags[`BTCALU_F_C] = udiff[48];
              next_st.flags[`BTCALU_F_V] = 1'b0;
              next_st.flags[`BTCALU_F_Z] = (udiff[47:0] == 48'h0);
              next_st.flags[`BTCALU_F_N] = udiff[47];
            end
            default: next_st.done = 1'b1;
          endcase
        end
      end
      btcalu_pkg::ST_FETCH: begin
        next_st.flags[`BTCALU_F_C] = pick_bit(mem_rdata, st.bit_q);
        next_st.done = 1'b1;
        next_st.state = btcalu_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st <= '{state: btcalu_pkg::ST_IDLE, flags: `BTCALU_FLAGS_RST, mode16: `BTCALU_MODE_RST,
              rdata: 8'h00, done: 1'b0, acc_wr_en: 1'b0, acc_wr_sel: 1'b0,
              acc_wr_data: 56'h0, mem_rd: 1'b0, mem_space: 1'b0, mem_addr: 24'h000000,
              bit_q: 5'h00, sp_dec: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign op_ready = (st.state == btcalu_pkg::ST_IDLE);
  assign reg_rdata = st.rdata;
  assign mem_rd = st.mem_rd;
  assign mem_space = st.mem_space;
  assign mem_addr = st.mem_addr;
  assign op_done = st.done;
  assign acc_wr_en = st.acc_wr_en;
  assign acc_wr_sel = st.acc_wr_sel;
  assign acc_wr_data = st.acc_wr_data;
  assign sp_dec = st.sp_dec;
  assign condition_flags = st.flags;

  logic take;
  assign take = op_valid & op_ready;

  bt_reg_carry_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_BIT_TEST && bt_src == btcalu_pkg::BT_REG && bit_num < 5'h18
    |=> condition_flags[0] == $past(reg_operand[bit_num]))
    else $error("bit test carry does not match tested bit");

  sp_dec_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_BIT_TEST
    |=> sp_dec == ($past(bt_src) == btcalu_pkg::BT_STACK))
    else $error("stack pointer decrement wrong");

  pp_window_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_BIT_TEST && bt_src == btcalu_pkg::BT_MEM_PP
    |=> mem_rd && mem_addr == {`BTCALU_PP_BASE, $past(addr_field)})
    else $error("peripheral window address wrong");

  mem_fetch_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_BIT_TEST && bt_src == btcalu_pkg::BT_MEM_EA
    |=> mem_rd && !op_done && mem_addr == $past(ea_addr) ##1 op_done && op_ready)
    else $error("memory bit test sequence wrong");

  lead_range_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_LEAD_COUNT
    |=> $signed(acc_wr_data[47:24]) <= 8 && $signed(acc_wr_data[47:24]) >= -47)
    else $error("count result out of range");

  lead_shape_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_LEAD_COUNT
    |=> acc_wr_en && acc_wr_data[23:0] == 24'h0 && acc_wr_data[55:48] == {8{acc_wr_data[47]}})
    else $error("count result shape wrong");

  lead_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_LEAD_COUNT && s1_acc == 56'h0
    |=> acc_wr_data == 56'h0 && condition_flags[2])
    else $error("zero source count not zero");

  lead_flags_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_LEAD_COUNT
    |=> !condition_flags[1] && condition_flags[3] == acc_wr_data[47]
        && condition_flags[0] == $past(condition_flags[0]))
    else $error("count flags wrong");

  clear_result_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_ACC_CLEAR
    |=> acc_wr_en && acc_wr_data == 56'h0 && condition_flags[2] && condition_flags[4]
        && !condition_flags[3] && !condition_flags[5] && !condition_flags[1])
    else $error("clear result or flags wrong");

  cmp_nowrite_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && (op_code == btcalu_pkg::OP_SIGNED_CMP || op_code == btcalu_pkg::OP_MAGN_CMP)
    |=> !acc_wr_en && condition_flags[2] == ($past(cmp_a) == $past(cmp_b)))
    else $error("compare wrote back or zero flag wrong");

  ucmp_flags_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_UNSIGNED_CMP
    |=> !condition_flags[1] && !acc_wr_en
        && condition_flags[2] == ($past(s2_acc[47:0]) == $past(u_s1)))
    else $error("unsigned compare flags wrong");

  mem_carry_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mem_rd && st.bit_q <= `BTCALU_BIT_MAX
    |=> condition_flags[0] == $past(mem_rdata[st.bit_q]))
    else $error("memory bit test carry wrong");

  abs_window_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_BIT_TEST && bt_src == btcalu_pkg::BT_MEM_ABS
    |=> mem_rd && mem_addr == {18'h00000, $past(addr_field)})
    else $error("absolute operand address wrong");

  qq_window_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_BIT_TEST && bt_src == btcalu_pkg::BT_MEM_QQ
    |=> mem_rd && mem_addr == {`BTCALU_QQ_BASE, $past(addr_field)})
    else $error("second peripheral window address wrong");

  lead_narrow_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_LEAD_COUNT && st.mode16
    |=> $signed(acc_wr_data[47:24]) <= 8 && $signed(acc_wr_data[47:24]) >= -31)
    else $error("sixteen-bit count result out of range");

  clear_keep_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_ACC_CLEAR
    |=> condition_flags[0] == $past(condition_flags[0])
        && condition_flags[7:6] == $past(condition_flags[7:6]))
    else $error("clear changed carry, limit or scaling");

  short_imm_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_SIGNED_CMP && s1_kind == btcalu_pkg::S1_IMM_SHORT
    |=> condition_flags[2] == ($past(s2_acc) == {26'h0, $past(s1_word[5:0]), 24'h000000}))
    else $error("short immediate not zero-extended");

  word_extend_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_SIGNED_CMP && s1_kind == btcalu_pkg::S1_WORD
    |=> condition_flags[2]
        == ($past(s2_acc) == {{8{$past(s1_word[23])}}, $past(s1_word), 24'h000000}))
    else $error("word operand extension wrong");

  unsigned_ext_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    take && op_code == btcalu_pkg::OP_UNSIGNED_CMP && s1_kind == btcalu_pkg::S1_ACC
    |=> condition_flags[2] == ($past(s2_acc[47:0]) == $past(s1_acc[47:0])))
    else $error("unsigned compare used extension byte");

endmodule

// file: pkg/btcalu_map.svh
/*
  Register offsets, flag bit positions, reset values and fixed constants
  of the bit test / count / compare data ALU.
  Assumes inclusion by bare name from the design file and the test bench.
*/
`ifndef BTCALU_MAP_SVH
`define BTCALU_MAP_SVH

// register offsets on the plain register port
`define BTCALU_OFS_FLAGS 4'h0
`define BTCALU_OFS_MODE 4'h1

// condition flag bit positions
`define BTCALU_F_C 0
`define BTCALU_F_V 1
`define BTCALU_F_Z 2
`define BTCALU_F_N 3
`define BTCALU_F_U 4
`define BTCALU_F_E 5
`define BTCALU_F_L 6
`define BTCALU_F_S 7

// mode register field
`define BTCALU_MODE_SIXTEEN 0

// reset values
`define BTCALU_FLAGS_RST 8'h00
`define BTCALU_MODE_RST 1'h0

// bit test limits and peripheral windows
`define BTCALU_BIT_MAX 5'h17
`define BTCALU_PP_BASE 18'h3FFFF
`define BTCALU_QQ_BASE 18'h3FFFE

// leading bit count constants
`define BTCALU_LEAD_BIAS 24'h000009
`define BTCALU_LEAD_W_NORMAL 7'h38
`define BTCALU_LEAD_W_SIXTEEN 7'h28

`endif

// file: pkg/btcalu_pkg.sv
/*
  Types of the bit test / count / compare data ALU: operation codes,
  operand sources, engine states and the packed state record.
  Assumes the constants header is on the include path.
*/
package btcalu_pkg;

  typedef enum logic [2:0] {
    OP_BIT_TEST = 3'b000,
    OP_LEAD_COUNT = 3'b001,
    OP_ACC_CLEAR = 3'b010,
    OP_SIGNED_CMP = 3'b011,
    OP_MAGN_CMP = 3'b100,
    OP_UNSIGNED_CMP = 3'b101
  } btcalu_op_e;

  // where the bit test operand comes from
  typedef enum logic [2:0] {
    BT_REG = 3'b000,
    BT_STACK = 3'b001,
    BT_MEM_EA = 3'b010,
    BT_MEM_ABS = 3'b011,
    BT_MEM_PP = 3'b100,
    BT_MEM_QQ = 3'b101
  } btcalu_btsrc_e;

  // first compare operand kind
  typedef enum logic [1:0] {
    S1_ACC = 2'b00,
    S1_WORD = 2'b01,
    S1_IMM_SHORT = 2'b10,
    S1_IMM_LONG = 2'b11
  } btcalu_s1_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_FETCH = 1'b1
  } btcalu_state_e;

  typedef struct packed {
    btcalu_state_e state;
    logic [7:0] flags;
    logic mode16;
    logic [7:0] rdata;
    logic done;
    logic acc_wr_en;
    logic acc_wr_sel;
    logic [55:0] acc_wr_data;
    logic mem_rd;
    logic mem_space;
    logic [23:0] mem_addr;
    logic [4:0] bit_q;
    logic sp_dec;
  } btcalu_state_s;

endpackage

// file: verification/btcalu_mem_model.sv
/*
  Memory behind the block's operand fetch: answers a read in the cycle of
  the request with a fixed function of space and address.
  Assumes mem_rd, mem_space and mem_addr come from the block's registers.
*/
`timescale 1ns/1ps
module btcalu_mem_model (
  // clock
  input wire logic ref_clk,
  // request
  input wire logic mem_rd,
  input wire logic mem_space,
  input wire logic [23:0] mem_addr,
  // answer
  output logic [23:0] mem_rdata
);
  logic [23:0] last = 24'h000000;

  // outside a read the bus shows a changing pattern, never stale data
  always_comb begin
    if (mem_rd)
      mem_rdata = mem_addr ^ (mem_space ? 24'hC3A55A : 24'h3C5AA5);
    else
      mem_rdata = ~last;
  end

  always_ff @(posedge ref_clk) begin
    last <= mem_rdata;
  end
endmodule

// file: verification/bit_test_count_compare_alu_test.sv
/*
  Self-checking bench for the bit test / count / compare data ALU.
  Assumes the design package and map header are on the include path.
*/
`timescale 1ns/1ps
`include "btcalu_map.svh"
module bit_test_count_compare_alu_test;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, op_valid = 1'b0, mem_space_sel = 1'b0, dest_sel = 1'b0;
  btcalu_pkg::btcalu_op_e op_code = btcalu_pkg::OP_BIT_TEST;
  btcalu_pkg::btcalu_btsrc_e bt_src = btcalu_pkg::BT_REG;
  btcalu_pkg::btcalu_s1_e s1_kind = btcalu_pkg::S1_ACC;
  logic [4:0] bit_num = 5'h00;
  logic [5:0] addr_field = 6'h00;
  logic [23:0] ea_addr = 24'h0, reg_operand = 24'h0, s1_word = 24'h0, imm_long = 24'h0;
  logic [55:0] s1_acc = 56'h0, s2_acc = 56'h0;
  logic [7:0] reg_rdata, condition_flags, rd, pre;
  logic op_ready, mem_rd, mem_space, op_done, acc_wr_en, acc_wr_sel, sp_dec, got_wr, got_sp;
  logic [23:0] mem_addr, mem_rdata, r24;
  logic [24:0] got_addr;
  logic [55:0] acc_wr_data;
  logic [23:0] want_a [4] = '{24'h123456, 24'h00003E, 24'hFFFFFD, 24'hFFFFBC};
  logic [55:0] lead_src [8] = '{56'h0, 56'h80_000000_000000, 56'h00_000000_000001,
    56'hFF_FFFFFF_FFFFFF, 56'h00_0FFFFF_000000, 56'h00_000000_0000FF,
    56'h00_000000_000100, 56'hFF_FFFFFF_FFFFFF};
  int n_fail = 0;
  int comparisons = 0;

  btcalu_core uut (.ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .bt_src(bt_src),
    .bit_num(bit_num), .addr_field(addr_field), .ea_addr(ea_addr),
    .mem_space_sel(mem_space_sel), .reg_operand(reg_operand), .s1_kind(s1_kind),
    .s1_acc(s1_acc), .s1_word(s1_word), .imm_long(imm_long), .s2_acc(s2_acc),
    .dest_sel(dest_sel), .mem_rd(mem_rd), .mem_space(mem_space), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .op_done(op_done), .acc_wr_en(acc_wr_en),
    .acc_wr_sel(acc_wr_sel), .acc_wr_data(acc_wr_data), .sp_dec(sp_dec),
    .condition_flags(condition_flags));

  btcalu_mem_model mem (.ref_clk(ref_clk), .mem_rd(mem_rd), .mem_space(mem_space),
    .mem_addr(mem_addr), .mem_rdata(mem_rdata));

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input string nm, input logic [55:0] want, input logic [55:0] got);
    comparisons++;
    if (got !== want) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, want, got);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // one request, then a bounded wait for completion
  task automatic fire();
    got_wr = 1'b0;
    got_sp = 1'b0;
    got_addr = 25'h0;
    @(posedge ref_clk);
    op_valid <= 1'b1;
    @(posedge ref_clk);
    op_valid <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (mem_rd === 1'b1) got_addr = {mem_space, mem_addr};
      got_wr = got_wr | (acc_wr_en === 1'b1);
      got_sp = got_sp | (sp_dec === 1'b1);
      if (op_done === 1'b1) break;
      @(posedge ref_clk);
    end
    check("done", 1, op_done);
  endtask

  function automatic logic [23:0] lead_ref(input logic [55:0] s, input logic m16);
    int cnt;
    logic run;
    logic nz;
    cnt = 0;
    run = 1'b1;
    nz = 1'b0;
    for (int b = 55; b >= 0; b--) begin
      if (!(m16 && (b inside {[24:31], [0:7]}))) begin
        nz = nz | s[b];
        if (run && s[b] == s[55]) cnt++;
        else run = 1'b0;
      end
    end
    return nz ? 24'(9 - cnt) : 24'h000000;
  endfunction

  function automatic logic [55:0] word56(input logic [23:0] w);
    return {{8{w[23]}}, w, 24'h000000};
  endfunction

  function automatic logic [55:0] mag(input logic [55:0] x);
    return x[55] ? -x : x;
  endfunction

  function automatic logic [7:0] sub_flags(input logic [55:0] a, input logic [55:0] b);
    logic [56:0] d;
    logic v;
    logic e;
    d = {1'b0, a} - {1'b0, b};
    v = (a[55] ^ b[55]) & (a[55] ^ d[55]);
    e = !(d[55:47] == 9'h000 || d[55:47] == 9'h1FF);
    return {1'b1, v, e, ~(d[47] ^ d[46]) & ~e, d[55], d[55:0] == 56'h0, v, d[56]};
  endfunction

  task automatic compare_case(input btcalu_pkg::btcalu_op_e op,
      input btcalu_pkg::btcalu_s1_e kd, input logic [55:0] a1, input logic [23:0] w,
      input logic [55:0] a2);
    logic [55:0] b;
    logic [48:0] d;
    logic [7:0] want;
    reg_write(`BTCALU_OFS_FLAGS, 8'h80);
    op_code <= op;
    s1_kind <= kd;
    s1_acc <= a1;
    s1_word <= (kd == btcalu_pkg::S1_IMM_LONG) ? ~w : w;
    imm_long <= w;
    s2_acc <= a2;
    fire();
    b = (kd == btcalu_pkg::S1_ACC) ? a1 : word56(w);
    if (kd == btcalu_pkg::S1_IMM_SHORT) b = word56({18'h0, w[5:0]});
    d = {1'b0, a2[47:0]} - {1'b0, (kd == btcalu_pkg::S1_ACC) ? a1[47:0] : {w, 24'h0}};
    if (op == btcalu_pkg::OP_UNSIGNED_CMP) want = {4'h8, d[47], d[47:0] == 48'h0, 1'b0, d[48]};
    else if (op == btcalu_pkg::OP_MAGN_CMP) want = sub_flags(mag(a2), mag(b));
    else want = sub_flags(a2, b);
    check("compare flags", want, condition_flags);
    check("compare writes", 0, got_wr);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    reg_read(`BTCALU_OFS_FLAGS, rd);
    check("flags reset", 8'h00, rd);
    reg_read(`BTCALU_OFS_MODE, rd);
    check("mode reset", 8'h00, rd);
    reg_write(4'h7, 8'hFF);
    reg_read(4'h7, rd);
    check("unmapped read", 8'h00, rd);
    reg_write(`BTCALU_OFS_FLAGS, 8'hA5);
    reg_read(`BTCALU_OFS_FLAGS, rd);
    check("flags write", 8'hA5, rd);
    $display("test registers done");
    for (int n = 0; n < 24; n++) begin
      pre = {8{n[0]}};
      reg_write(`BTCALU_OFS_FLAGS, pre);
      reg_operand <= 24'hA5C3F1;
      bit_num <= 5'(n);
      bt_src <= n[1] ? btcalu_pkg::BT_STACK : btcalu_pkg::BT_REG;
      fire();
      check("bit test carry", {pre[7:1], reg_operand[n]}, condition_flags);
      check("stack pointer", n[1], got_sp);
    end
    for (int k = 0; k < 4; k++) begin
      reg_write(`BTCALU_OFS_FLAGS, 8'h00);
      bt_src <= btcalu_pkg::btcalu_btsrc_e'(3'(k + 2));
      mem_space_sel <= k[0];
      ea_addr <= 24'h123456;
      addr_field <= 6'h3F - 6'(k);
      bit_num <= 5'(k * 7);
      fire();
      r24 = want_a[k] ^ (k[0] ? 24'hC3A55A : 24'h3C5AA5);
      check("fetch address", {k[0], want_a[k]}, got_addr);
      check("memory carry", {7'h00, r24[k * 7]}, condition_flags);
    end
    $display("test bit test done");
    for (int k = 0; k < 8; k++) begin
      if (k == 5) reg_write(`BTCALU_OFS_MODE, 8'h01);
      reg_write(`BTCALU_OFS_FLAGS, 8'hF3);
      op_code <= btcalu_pkg::OP_LEAD_COUNT;
      s1_acc <= lead_src[k];
      dest_sel <= k[0];
      fire();
      r24 = lead_ref(lead_src[k], k >= 5);
      check("count data", {{8{r24[23]}}, r24, 24'h0},
        acc_wr_data);
      check("count write", {k[0], 1'b1}, {acc_wr_sel, got_wr});
      check("count flags", {4'hF, r24[23], r24 == 24'h0, 2'b01}, condition_flags);
    end
    reg_write(`BTCALU_OFS_MODE, 8'h00);
    $display("test count done");
    op_code <= btcalu_pkg::OP_ACC_CLEAR;
    for (int k = 0; k < 2; k++) begin
      pre = k ? 8'h2A : 8'hEB;
      reg_write(`BTCALU_OFS_FLAGS, pre);
      dest_sel <= k[0];
      fire();
      check("clear data", 56'h0, acc_wr_data);
      check("clear write", {k[0], 1'b1}, {acc_wr_sel, got_wr});
      check("clear flags", {pre[7:6], 5'b01010, pre[0]}, condition_flags);
    end
    $display("test clear done");
    compare_case(btcalu_pkg::OP_SIGNED_CMP, btcalu_pkg::S1_ACC, 56'h10_000000, 24'h0,
      56'h10_000000);
    compare_case(btcalu_pkg::OP_SIGNED_CMP, btcalu_pkg::S1_WORD, 56'h0, 24'h800000, 56'h0);
    compare_case(btcalu_pkg::OP_SIGNED_CMP, btcalu_pkg::S1_IMM_SHORT, 56'h0, 24'hFFFFC5,
      56'h05_000000);
    compare_case(btcalu_pkg::OP_SIGNED_CMP, btcalu_pkg::S1_IMM_LONG, 56'h0, 24'h7FFFFF,
      56'h80_000000_000000);
    compare_case(btcalu_pkg::OP_MAGN_CMP, btcalu_pkg::S1_ACC, 56'hFF_FFFFF0_000000, 24'h0,
      56'h08_000000);
    compare_case(btcalu_pkg::OP_MAGN_CMP, btcalu_pkg::S1_WORD, 56'h0, 24'hFFFFF8,
      56'hFF_FFFFF8_000000);
    compare_case(btcalu_pkg::OP_UNSIGNED_CMP, btcalu_pkg::S1_WORD, 56'h0, 24'h000001,
      56'hFF_000001_000000);
    compare_case(btcalu_pkg::OP_UNSIGNED_CMP, btcalu_pkg::S1_ACC, 56'h00_FFFFFF_FFFFFF, 24'h0,
      56'h7F_000000_000000);
    $display("test compare done");
    report_and_stop();
  end
endmodule
